// ### hw/psm_cfg.svh
// Register offset, field positions, reset values and timing counts for the power controller.
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

`define PSM_PWRCTL_ADDR        8'h87
`define PSM_PWRCTL_RESET       8'h00
`define PSM_BIT_IDLE           0
`define PSM_BIT_PDOWN          1
`define PSM_BIT_U2_TXSEL       2
`define PSM_BIT_U2_RXSEL       3
`define PSM_BIT_ADC_IRQ_EN     4
`define PSM_BIT_LV_RST_DIS     5
`define PSM_BIT_U2_BAUD_DBL    6
`define PSM_BIT_U1_BAUD_DBL    7
`define PSM_CYCLE_CLOCKS       12
`define PSM_EXT_RST_CYCLES     2
`define PSM_INT_RESTART_CYCLES 3

`endif

// ### hw/psm_pkg.sv
// Types shared by the power-saving mode controller.
package psm_pkg;

	typedef enum logic [1:0] {
		PSM_RUN,
		PSM_IDLE,
		PSM_PDOWN,
		PSM_RESTART
	} psm_state_t;

	// Special function register access from the core.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} psm_sfr_req_t;

	// Configuration bits fanned out to the peripherals.
	typedef struct packed {
		logic u1_baud_double;
		logic u2_baud_double;
		logic lowvolt_reset_disable;
		logic converter_irq_enable;
		logic u2_rx_clock_select;
		logic u2_tx_clock_select;
	} psm_cfg_t;

endpackage

// ### hw/psm_power_ctrl.sv
// Power-saving mode controller: power control register, idle and power-down.
`timescale 1ns/1ns
`default_nettype none
`include "psm_cfg.svh"

// Summary of operation
// - Bit 1 write enters power-down mode
// - Bit 0 write enters idle mode
// - Idle halts core, keeps all state
// - Peripherals stay clocked during idle
// - Enabled interrupt clears idle bit, resumes
// - Interrupt or any reset ends idle
// - Internal reset restarts after three cycles
// - Power-down stops the oscillator
// - Power-down keeps RAM and registers
// - Only reset leaves power-down
// - Low-voltage detect stays on in power-down
// - Bit 5 disables low-voltage reset
// - Bits 7,6 double baud; bit 4 converter irq
// - Low-voltage reset enabled after power-up
module psm_power_ctrl
	import psm_pkg::*;
#(
	parameter int CYCLE_CLOCKS    = `PSM_CYCLE_CLOCKS,
	parameter int RESTART_CYCLES  = `PSM_INT_RESTART_CYCLES
) (
	input  wire logic         CLK,
	input  wire logic         RST_N,
	input  wire psm_sfr_req_t SFR_REQ,
	input  wire logic         IRQ_PENDING,
	input  wire logic         INT_RESET,
	input  wire logic         LOWVOLT_DETECT,
	output logic [7:0]        SFR_RDATA,
	output logic              SFR_HIT,
	output logic              CPU_CLK_EN,
	output logic              PERIPH_CLK_EN,
	output logic              OSC_RUN,
	output logic              LOWVOLT_DETECT_EN,
	output logic              LOWVOLT_RESET,
	output logic              CPU_RESTART_HOLD,
	output logic              MACHINE_CYCLE,
	output psm_cfg_t          CFG
);

	logic [7:0]  power_control_reg_q;
	logic [7:0]  power_control_reg_d;
	psm_state_t  state_q;
	psm_state_t  state_d;
	logic [3:0]  phase_q;
	logic [1:0]  restart_cnt_q;
	logic        int_reset_q;
	logic        hit_wr;
	logic        hit_rd;
	logic        idle_request;
	logic        powerdown_request;

	assign hit_wr = SFR_REQ.wr && (SFR_REQ.addr == `PSM_PWRCTL_ADDR);
	assign hit_rd = SFR_REQ.rd && (SFR_REQ.addr == `PSM_PWRCTL_ADDR);
	assign idle_request      = power_control_reg_q[`PSM_BIT_IDLE];
	assign powerdown_request = power_control_reg_q[`PSM_BIT_PDOWN];

	// Machine cycle tick; it keeps running in idle so peripherals count.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase_q <= 4'h0;
		end else if (phase_q == 4'(CYCLE_CLOCKS - 1)) begin
			phase_q <= 4'h0;
		end else begin
			phase_q <= phase_q + 4'h1;
		end
	end

	assign MACHINE_CYCLE = (phase_q == 4'(CYCLE_CLOCKS - 1)) && OSC_RUN;

	// Next value of the register. Hardware clearing of the idle bit on an
	// interrupt wins over a software write in that same cycle, because a
	// halted core cannot be writing anyway.
	always_comb begin
		power_control_reg_d = power_control_reg_q;
		if (hit_wr) begin
			power_control_reg_d = SFR_REQ.wdata;
		end
		if (state_q == PSM_IDLE && IRQ_PENDING) begin
			power_control_reg_d[`PSM_BIT_IDLE] = 1'b0;
		end
	end

	// The register holds through both low-power modes; reset clears it,
	// which also leaves the low-voltage reset enabled.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			power_control_reg_q <= `PSM_PWRCTL_RESET;
		end else if (INT_RESET) begin
			power_control_reg_q <= `PSM_PWRCTL_RESET;
		end else begin
			power_control_reg_q <= power_control_reg_d;
		end
	end

	// Mode sequencing. Power-down is checked first so a write of both
	// bits ends in power-down.
	always_comb begin
		state_d = state_q;
		case (state_q)
			PSM_RUN: begin
				if (powerdown_request) begin
					state_d = PSM_PDOWN;
				end else if (idle_request) begin
					state_d = PSM_IDLE;
				end
			end
			PSM_IDLE: begin
				if (IRQ_PENDING) begin
					state_d = PSM_RUN;
				end
			end
			PSM_PDOWN: begin
				state_d = PSM_PDOWN;
			end
			default: begin
				if (restart_cnt_q == 2'(RESTART_CYCLES - 1) &&
				    MACHINE_CYCLE) begin
					state_d = PSM_RUN;
				end
			end
		endcase
		if (int_reset_q) begin
			state_d = PSM_RESTART;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= PSM_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Internal reset level is registered one clock so the restart count starts once
	// the reset has been released.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			int_reset_q <= 1'b0;
		end else begin
			int_reset_q <= INT_RESET;
		end
	end

	// Three machine cycles of restart delay after an internal reset.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			restart_cnt_q <= 2'h0;
		end else if (state_q != PSM_RESTART || int_reset_q) begin
			restart_cnt_q <= 2'h0;
		end else if (MACHINE_CYCLE) begin
			restart_cnt_q <= restart_cnt_q + 2'h1;
		end
	end

	// Clock gating: the core stops in idle with its state intact, while the
	// peripheral clock stays on; power-down stops the oscillator itself.
	assign CPU_CLK_EN       = (state_q == PSM_RUN) && !powerdown_request &&
	                          !idle_request;
	assign PERIPH_CLK_EN    = (state_q != PSM_PDOWN);
	assign OSC_RUN          = (state_q != PSM_PDOWN);
	assign CPU_RESTART_HOLD = (state_q == PSM_RESTART);

	// Low-voltage detection is never gated by the power modes.
	assign LOWVOLT_DETECT_EN = 1'b1;
	assign LOWVOLT_RESET     = LOWVOLT_DETECT &&
	                           !power_control_reg_q[`PSM_BIT_LV_RST_DIS];

	// Configuration fan-out to the serial ports and converter.
	always_comb begin
		CFG.u1_baud_double        = power_control_reg_q[`PSM_BIT_U1_BAUD_DBL];
		CFG.u2_baud_double        = power_control_reg_q[`PSM_BIT_U2_BAUD_DBL];
		CFG.lowvolt_reset_disable = power_control_reg_q[`PSM_BIT_LV_RST_DIS];
		CFG.converter_irq_enable  = power_control_reg_q[`PSM_BIT_ADC_IRQ_EN];
		CFG.u2_rx_clock_select    = power_control_reg_q[`PSM_BIT_U2_RXSEL];
		CFG.u2_tx_clock_select    = power_control_reg_q[`PSM_BIT_U2_TXSEL];
	end

	// Read data is registered so the core sees it one clock after the strobe.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SFR_RDATA <= 8'h00;
			SFR_HIT   <= 1'b0;
		end else begin
			SFR_RDATA <= hit_rd ? power_control_reg_q : 8'h00;
			SFR_HIT   <= hit_rd;
		end
	end

endmodule
`default_nettype wire

// ### testbench/psm_core_model.sv
// Core and reset-source model: wake-up interrupt and external reset pulse.
`timescale 1ns/1ns
`default_nettype none
module psm_core_model (
	input  wire logic clk,
	input  wire logic wake,
	input  wire logic kick,
	input  wire logic cpu_clk_en,
	output logic      irq_pending,
	output logic      ext_rst_n
);
	logic [4:0] hold_q = 5'h00;
	// The interrupt stays pending until the core runs, so a halted core sees it.
	always_ff @(posedge clk) irq_pending <= wake && !cpu_clk_en;
	// External reset is held for two machine cycles of twelve clocks.
	always_ff @(posedge clk) hold_q <= kick ? 5'h18 : hold_q - 5'(hold_q != 0);
	assign ext_rst_n = hold_q == 5'h00;
endmodule
`default_nettype wire

// ### testbench/psm_power_ctrl_sva.sv
// Port assertions for the power-saving mode controller.
`timescale 1ns/1ns
`default_nettype none
module psm_power_ctrl_sva
	import psm_pkg::*;
#(
	parameter int CYCLE_CLOCKS   = 12,
	parameter int RESTART_CYCLES = 3
) (
	input wire logic         CLK,
	input wire logic         RST_N,
	input wire psm_sfr_req_t SFR_REQ,
	input wire logic         IRQ_PENDING,
	input wire logic         INT_RESET,
	input wire logic         LOWVOLT_DETECT,
	input wire logic [7:0]   SFR_RDATA,
	input wire logic         SFR_HIT,
	input wire logic         CPU_CLK_EN,
	input wire logic         OSC_RUN,
	input wire logic         LOWVOLT_RESET,
	input wire logic         CPU_RESTART_HOLD,
	input wire psm_cfg_t     CFG
);
	// Slack of one machine cycle plus three clocks covers the unknown phase of the first pulse.
	localparam int LO = (RESTART_CYCLES - 1) * CYCLE_CLOCKS - 1;
	localparam int SL = CYCLE_CLOCKS + 3;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire logic hit = SFR_REQ.addr == 8'h87;
	wire logic go = SFR_REQ.wr && hit && !INT_RESET && !IRQ_PENDING;
	property p_idle; go && SFR_REQ.wdata[1:0] == 2'b01 |=> !CPU_CLK_EN && OSC_RUN; endproperty
	a_idle: assert property (p_idle) else $error("idle entry wrong");
	property p_pdown; go && SFR_REQ.wdata[1] |=> !CPU_CLK_EN ##1 !OSC_RUN; endproperty
	a_pdown: assert property (p_pdown) else $error("power-down entry wrong");
	// An internal reset leaves power-down two edges later, so skip that edge too.
	property p_pdstay; !OSC_RUN && !INT_RESET && !$past(INT_RESET) |=> !OSC_RUN; endproperty
	a_pdstay: assert property (p_pdstay) else $error("left power-down");
	property p_wake; !CPU_CLK_EN && $past(CPU_CLK_EN) == 1'b0 && OSC_RUN && !$past(INT_RESET)
		&& !CPU_RESTART_HOLD && IRQ_PENDING |=> CPU_CLK_EN; endproperty
	a_wake: assert property (p_wake) else $error("interrupt did not end idle");
	property p_rd; SFR_REQ.rd && hit && !SFR_REQ.wr && !INT_RESET |=> SFR_HIT && SFR_RDATA[7:4]
		== {CFG.u1_baud_double, CFG.u2_baud_double, CFG[3:2]}; endproperty
	a_rd: assert property (p_rd) else $error("read back wrong");
	property p_lvr; LOWVOLT_RESET == (LOWVOLT_DETECT && !CFG.lowvolt_reset_disable); endproperty
	a_lvr: assert property (p_lvr) else $error("low-voltage reset wrong");
	property p_intrst; INT_RESET |=> CFG == '0; endproperty
	a_intrst: assert property (p_intrst) else $error("register not cleared");
	property p_restart; $rose(CPU_RESTART_HOLD) |-> ##LO CPU_RESTART_HOLD ##[1:SL] !CPU_RESTART_HOLD; endproperty
	a_restart: assert property (p_restart) else $error("restart length wrong");
endmodule
bind psm_power_ctrl psm_power_ctrl_sva #(.CYCLE_CLOCKS(CYCLE_CLOCKS), .RESTART_CYCLES(RESTART_CYCLES))
	psm_power_ctrl_sva_i (.CLK, .RST_N, .SFR_REQ, .IRQ_PENDING, .INT_RESET, .LOWVOLT_DETECT,
	.SFR_RDATA, .SFR_HIT, .CPU_CLK_EN, .OSC_RUN, .LOWVOLT_RESET, .CPU_RESTART_HOLD, .CFG);
`default_nettype wire

// ### testbench/power_saving_mode_control_test.sv
// Self-checking bench for the power-saving mode controller.
`timescale 1ns/1ns
`default_nettype none
module power_saving_mode_control_test;
	import psm_pkg::*;
	logic CLK = 0, INIT_N = 0, INT_RESET = 0, LOWVOLT_DETECT = 1, WAKE = 0, KICK = 0;
	logic EXT_RST_N, IRQ_PENDING, SFR_HIT, CPU_CLK_EN, PERIPH_CLK_EN, OSC_RUN;
	logic LOWVOLT_DETECT_EN, LOWVOLT_RESET, CPU_RESTART_HOLD;
	logic [7:0] SFR_RDATA;
	logic [7:0] cv [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0c};
	psm_sfr_req_t SFR_REQ = '0;
	psm_cfg_t CFG;
	int num_errors = 0, compares = 0;
	wire logic RST_N = INIT_N & EXT_RST_N;
	wire logic [7:0] ST = {3'h0, LOWVOLT_DETECT_EN, CPU_CLK_EN, PERIPH_CLK_EN, OSC_RUN, LOWVOLT_RESET};
	always #25 CLK = ~CLK;
	psm_power_ctrl psm_power_ctrl_i (.CLK, .RST_N, .SFR_REQ, .IRQ_PENDING, .INT_RESET,
		.LOWVOLT_DETECT, .SFR_RDATA, .SFR_HIT, .CPU_CLK_EN, .PERIPH_CLK_EN, .OSC_RUN,
		.LOWVOLT_DETECT_EN, .LOWVOLT_RESET, .CPU_RESTART_HOLD, .MACHINE_CYCLE(), .CFG);
	psm_core_model psm_core_model_i (.clk(CLK), .wake(WAKE), .kick(KICK),
		.cpu_clk_en(CPU_CLK_EN), .irq_pending(IRQ_PENDING), .ext_rst_n(EXT_RST_N));
	// Compare and count; unknowns never match.
	task automatic chk(input string what, input logic [7:0] exp, got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Each access waits an edge first, so two accesses never share a time step.
	task automatic wr(input logic [7:0] a, d);
		@(posedge CLK) SFR_REQ <= '{1'b1, 1'b0, a, d};
		@(posedge CLK) SFR_REQ <= '0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge CLK) SFR_REQ <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge CLK) SFR_REQ <= '0;
		#1 chk("read data", exp, SFR_RDATA);
		chk("read hit", {7'h00, a == 8'h87}, {7'h00, SFR_HIT});
	endtask
	task automatic wait_run;
		for (int i = 0; i < 200; i++) begin
			@(posedge CLK);
			#1 if (CPU_CLK_EN === 1'b1 && CPU_RESTART_HOLD === 1'b0) break;
		end
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// The whole run takes well under a thousand cycles.
	initial begin
		#200000;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge CLK);
		INIT_N <= 1'b1;
		rd(8'h87, 8'h00);
		chk("status", 8'h1f, ST);
		$display("test done: reset");
		foreach (cv[i]) begin
			wr(8'h87, cv[i]);
			rd(8'h87, cv[i]);
			chk("cfg", {2'b00, cv[i][7:2]}, {2'b00, CFG});
			chk("status", 8'h1e | {7'h00, ~cv[i][5]}, ST);
		end
		wr(8'h88, 8'hff);
		rd(8'h88, 8'h00);
		rd(8'h87, 8'h0c);
		$display("test done: config");
		wr(8'h87, 8'h01);
		repeat (3) @(posedge CLK);
		#1 chk("idle status", 8'h17, ST);
		@(posedge CLK) WAKE <= 1'b1;
		wait_run;
		WAKE <= 1'b0;
		chk("woken status", 8'h1f, ST);
		rd(8'h87, 8'h00);
		$display("test done: idle");
		wr(8'h87, 8'h01);
		@(posedge CLK) INT_RESET <= 1'b1;
		@(posedge CLK) INT_RESET <= 1'b0;
		wait_run;
		chk("restart status", 8'h1f, ST);
		rd(8'h87, 8'h00);
		$display("test done: internal reset");
		wr(8'h87, 8'h03);
		repeat (3) @(posedge CLK);
		#1 chk("pdown status", 8'h11, ST);
		@(posedge CLK) WAKE <= 1'b1;
		repeat (40) @(posedge CLK);
		#1 chk("pdown held", 8'h11, ST);
		@(posedge CLK) KICK <= 1'b1;
		@(posedge CLK) KICK <= 1'b0;
		WAKE <= 1'b0;
		repeat (26) @(posedge CLK);
		wait_run;
		chk("reset status", 8'h1f, ST);
		rd(8'h87, 8'h00);
		$display("test done: power-down");
		test_done;
	end
endmodule
`default_nettype wire
